// ===== logic/t1b_defines.svh
// Purpose: Offsets, fields, reset values and counts for the T1 message
//          and data-link slot mapping block.
// Assumes: Register index times four is the AXI byte address.
// Notes:   Definitions only.
//
// Functional notes
// - A transmit code other than all ones is sent as a message.
// - Pattern is 11111110, code bits 0 to 5, then 0, on F-bit link.
// - Message send and receive validation work only in extended superframe.
// - Selector 0: declare on match, 8 of 10 equal, differs from last.
// - Selector 1: declare on match, 4 of 5 equal, differs from last.
// - Declared code loads received field, top bit holds message LSB.
// - Update flag sets on each field load, cleared by writing 1.
// - Interrupt output is flag gated by the message interrupt enable.
// - Transmit link 2 and 3 enables switch each transmitter on or off.
// - Transmit link 1 enable acts only in superframe or DM formats.
// - Receive link 2 and 3 enables switch each receiver on or off.
// - Receive link 1 enable acts only in superframe or DM formats.
// - Transmit even and odd selects gate insertion per frame parity.
// - Channel number 0 to 23 is binary, selecting channels 1 to 24.
// - Channel number ignored, nothing inserted, when both selects are 0.
// - Mask bit 7 enables the first transmitted, most significant bit.
// - Mask has no effect when both frame selects of the link are 0.
// - Links 2 and 3 have separate assignment and mask, both directions.
// - Receive even select gates extraction from even frames.
// - Receive odd select gates odd frames; channel and mask as transmit.
`ifndef T1B_DEFINES_SVH
`define T1B_DEFINES_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define T1B_IDX_TXCODE 10'h080
`define T1B_IDX_MSGCTL 10'h081
`define T1B_IDX_MSGIND 10'h082
`define T1B_IDX_RXCODE 10'h083
`define T1B_IDX_TXEN 10'h084
`define T1B_IDX_TXASG2 10'h086
`define T1B_IDX_TXASG3 10'h087
`define T1B_IDX_TXMSK2 10'h089
`define T1B_IDX_TXMSK3 10'h08A
`define T1B_IDX_RXEN 10'h08B
`define T1B_IDX_RXASG2 10'h08D
`define T1B_IDX_RXASG3 10'h08E
`define T1B_IDX_RXMSK2 10'h090
`define T1B_IDX_RXMSK3 10'h091
`define T1B_IDX_FMT 10'h0A0

// ----------------------------------------
// Fields, reset values, counts
// ----------------------------------------
`define T1B_BIT_VALSEL 5
`define T1B_BIT_IRQEN 4
`define T1B_BIT_EVEN 6
`define T1B_BIT_ODD 5
`define T1B_BIT_ESF 0
`define T1B_BIT_DM 1
`define T1B_CODE_NONE 6'h3F
`define T1B_HDR 8'hFE
`define T1B_PAT_LAST 4'hE
`define T1B_WIN_STRICT 4'hA
`define T1B_WIN_FAST 4'h5
`define T1B_NEED_STRICT 4'h8
`define T1B_NEED_FAST 4'h4
`define T1B_LAST_CH 5'h17
`define T1B_RESP_OKAY 2'h0
`define T1B_RESP_SLVERR 2'h2

`endif

// ===== logic/t1b_pkg.sv
// Purpose: Types shared by the message and slot mapping block.
// Assumes: Constants live in t1b_defines.svh.
// Notes:   Whole module state is one packed struct.
package t1b_pkg;

   typedef enum logic {TX_IDLE, TX_SEND} t1b_tx_e;

   typedef struct packed {
      logic stb;
      logic odd;
      logic [4:0] chan;
      logic [2:0] bitn;
   } t1b_slot_s;

   typedef struct packed {
      logic [5:0] tx_code;
      logic val_sel;
      logic irq_en;
      logic flag;
      logic [5:0] rx_code;
      logic [2:0] tx_en;
      logic [2:0] rx_en;
      logic [1:0] fmt;
      logic [1:0][6:0] tx_asg;
      logic [1:0][6:0] rx_asg;
      logic [1:0][7:0] tx_msk;
      logic [1:0][7:0] rx_msk;
      t1b_tx_e tx_st;
      logic [14:0] tx_sh;
      logic [3:0] tx_cnt;
      logic tx_bit;
      logic tx_act;
      logic [14:0] rx_sh;
      logic [9:0][5:0] hist;
      logic [9:0] hval;
      logic [1:0] tx_ins;
      logic [1:0] rx_ext;
      logic aw_ok;
      logic w_ok;
      logic [9:0] widx;
      logic [7:0] wdat;
      logic wstb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } t1b_state_s;

endpackage : t1b_pkg

// ===== logic/t1b_top.sv
// Purpose: ESF bit-oriented message send/receive and link 2/3 slot mapping.
// Assumes: Line strobes and slot position are synchronous to aclk.
// Notes:   AXI4-Lite slave, byte address is register index times four.
`timescale 1ns/1ps
`include "t1b_defines.svh"

module t1b_top #(
   parameter int ADDR_W = 12
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic tx_dl_stb,
   input wire logic rx_dl_stb,
   input wire logic rx_dl_bit,
   input wire t1b_pkg::t1b_slot_s tx_slot,
   input wire t1b_pkg::t1b_slot_s rx_slot,
   output logic tx_dl_bit,
   output logic tx_dl_active,
   output logic [1:0] tx_ins,
   output logic [1:0] rx_ext,
   output logic [2:0] tx_link_en,
   output logic [2:0] rx_link_en,
   output logic msg_irq
);

   if (ADDR_W < 12) begin : g_chk
      $error("ADDR_W must cover the register indices");
   end

   t1b_pkg::t1b_state_s st_r;
   t1b_pkg::t1b_state_s st_nxt;

   logic esf;
   logic lk1_ok;
   logic wr;
   logic [9:0] ridx;
   logic [14:0] rx_sh_n;
   logic [5:0] rx_c;
   logic [3:0] cnt;
   logic [3:0] win;
   logic [3:0] need;
   logic [14:0] pat;

   assign esf = st_r.fmt[`T1B_BIT_ESF];
   assign lk1_ok = st_r.fmt[`T1B_BIT_ESF] | st_r.fmt[`T1B_BIT_DM];
   assign ridx = araddr[11:2];
   assign wr = st_r.aw_ok & st_r.w_ok & ~st_r.bvalid & st_r.wstb;

   // ----------------------------------------
   // Slot match, shared by both links and directions
   // ----------------------------------------
   function automatic logic slot_hit(input logic [6:0] asg,
                                     input logic [7:0] msk,
                                     input t1b_pkg::t1b_slot_s s);
      logic par;
      par = s.odd ? asg[`T1B_BIT_ODD] : asg[`T1B_BIT_EVEN];
      // Both selects low: parity gate already blocks channel and mask
      return s.stb & par & (s.chan == asg[4:0])
             & msk[3'h7 - s.bitn];
   endfunction : slot_hit

   // ----------------------------------------
   // Register read mux
   // ----------------------------------------
   function automatic logic [7:0] rd_reg(input t1b_pkg::t1b_state_s s,
                                         input logic [9:0] i);
      case (i)
         `T1B_IDX_TXCODE: rd_reg = {2'h0, s.tx_code};
         `T1B_IDX_MSGCTL: rd_reg = {2'h0, s.val_sel, s.irq_en, 4'h0};
         `T1B_IDX_MSGIND: rd_reg = {7'h00, s.flag};
         `T1B_IDX_RXCODE: rd_reg = {2'h0, s.rx_code};
         `T1B_IDX_TXEN: rd_reg = {5'h00, s.tx_en};
         `T1B_IDX_TXASG2: rd_reg = {1'b0, s.tx_asg[0]};
         `T1B_IDX_TXASG3: rd_reg = {1'b0, s.tx_asg[1]};
         `T1B_IDX_TXMSK2: rd_reg = s.tx_msk[0];
         `T1B_IDX_TXMSK3: rd_reg = s.tx_msk[1];
         `T1B_IDX_RXEN: rd_reg = {5'h00, s.rx_en};
         `T1B_IDX_RXASG2: rd_reg = {1'b0, s.rx_asg[0]};
         `T1B_IDX_RXASG3: rd_reg = {1'b0, s.rx_asg[1]};
         `T1B_IDX_RXMSK2: rd_reg = s.rx_msk[0];
         `T1B_IDX_RXMSK3: rd_reg = s.rx_msk[1];
         `T1B_IDX_FMT: rd_reg = {6'h00, s.fmt};
         default: rd_reg = 8'h00;
      endcase
   endfunction : rd_reg

   function automatic logic mapped(input logic [9:0] i);
      case (i)
         `T1B_IDX_TXCODE, `T1B_IDX_MSGCTL, `T1B_IDX_MSGIND,
         `T1B_IDX_RXCODE, `T1B_IDX_TXEN, `T1B_IDX_TXASG2,
         `T1B_IDX_TXASG3, `T1B_IDX_TXMSK2, `T1B_IDX_TXMSK3,
         `T1B_IDX_RXEN, `T1B_IDX_RXASG2, `T1B_IDX_RXASG3,
         `T1B_IDX_RXMSK2, `T1B_IDX_RXMSK3, `T1B_IDX_FMT: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction : mapped

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      rx_sh_n = {st_r.rx_sh[13:0], rx_dl_bit};
      rx_c = rx_sh_n[6:1];
      pat = {`T1B_HDR, st_r.tx_code[0], st_r.tx_code[1], st_r.tx_code[2],
             st_r.tx_code[3], st_r.tx_code[4], st_r.tx_code[5], 1'b0};
      win = st_r.val_sel ? `T1B_WIN_FAST : `T1B_WIN_STRICT;
      need = st_r.val_sel ? `T1B_NEED_FAST : `T1B_NEED_STRICT;
      cnt = 4'h0;

      // AXI write channels, address and data in either order
      if (awvalid && awready) begin
         st_nxt.aw_ok = 1'b1;
         st_nxt.widx = awaddr[11:2];
      end
      if (wvalid && wready) begin
         st_nxt.w_ok = 1'b1;
         st_nxt.wdat = wdata[7:0];
         st_nxt.wstb = wstrb[0];
      end
      if (st_r.aw_ok && st_r.w_ok && !st_r.bvalid) begin
         st_nxt.aw_ok = 1'b0;
         st_nxt.w_ok = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = mapped(st_r.widx) ? `T1B_RESP_OKAY
                                          : `T1B_RESP_SLVERR;
      end
      if (st_r.bvalid && bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (wr) begin
         case (st_r.widx)
            `T1B_IDX_TXCODE: st_nxt.tx_code = st_r.wdat[5:0];
            `T1B_IDX_MSGCTL: begin
               st_nxt.val_sel = st_r.wdat[`T1B_BIT_VALSEL];
               st_nxt.irq_en = st_r.wdat[`T1B_BIT_IRQEN];
            end
            `T1B_IDX_MSGIND: st_nxt.flag = st_r.flag & ~st_r.wdat[0];
            `T1B_IDX_TXEN: st_nxt.tx_en = st_r.wdat[2:0];
            `T1B_IDX_TXASG2: st_nxt.tx_asg[0] = st_r.wdat[6:0];
            `T1B_IDX_TXASG3: st_nxt.tx_asg[1] = st_r.wdat[6:0];
            `T1B_IDX_TXMSK2: st_nxt.tx_msk[0] = st_r.wdat;
            `T1B_IDX_TXMSK3: st_nxt.tx_msk[1] = st_r.wdat;
            `T1B_IDX_RXEN: st_nxt.rx_en = st_r.wdat[2:0];
            `T1B_IDX_RXASG2: st_nxt.rx_asg[0] = st_r.wdat[6:0];
            `T1B_IDX_RXASG3: st_nxt.rx_asg[1] = st_r.wdat[6:0];
            `T1B_IDX_RXMSK2: st_nxt.rx_msk[0] = st_r.wdat;
            `T1B_IDX_RXMSK3: st_nxt.rx_msk[1] = st_r.wdat;
            `T1B_IDX_FMT: st_nxt.fmt = st_r.wdat[1:0];
            default: st_nxt.fmt = st_r.fmt;
         endcase
      end

      // AXI read
      if (arvalid && arready) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata = {24'h000000, rd_reg(st_r, ridx)};
         st_nxt.rresp = mapped(ridx) ? `T1B_RESP_OKAY : `T1B_RESP_SLVERR;
      end else if (st_r.rvalid && rready) begin
         st_nxt.rvalid = 1'b0;
      end

      // Message transmit, one bit per data-link slot
      if (!esf) begin
         st_nxt.tx_st = t1b_pkg::TX_IDLE;
         st_nxt.tx_act = 1'b0;
         st_nxt.tx_bit = 1'b1;
         st_nxt.tx_cnt = 4'h0;
      end else if (tx_dl_stb) begin
         case (st_r.tx_st)
            t1b_pkg::TX_IDLE: begin
               if (st_r.tx_code != `T1B_CODE_NONE) begin
                  st_nxt.tx_st = t1b_pkg::TX_SEND;
                  st_nxt.tx_bit = pat[14];
                  st_nxt.tx_sh = {pat[13:0], 1'b0};
                  st_nxt.tx_cnt = `T1B_PAT_LAST;
                  st_nxt.tx_act = 1'b1;
               end else begin
                  st_nxt.tx_act = 1'b0;
                  st_nxt.tx_bit = 1'b1;
               end
            end
            t1b_pkg::TX_SEND: begin
               st_nxt.tx_bit = st_r.tx_sh[14];
               st_nxt.tx_sh = {st_r.tx_sh[13:0], 1'b0};
               st_nxt.tx_cnt = st_r.tx_cnt - 4'h1;
               // Last bit sent: next slot reloads, so code changes land here
               if (st_r.tx_cnt == 4'h1) begin
                  st_nxt.tx_st = t1b_pkg::TX_IDLE;
               end
            end
            default: st_nxt.tx_st = t1b_pkg::TX_IDLE;
         endcase
      end

      // Message receive and validation
      if (esf && rx_dl_stb) begin
         st_nxt.rx_sh = rx_sh_n;
         if (rx_sh_n[14:7] == `T1B_HDR && !rx_sh_n[0]) begin
            // Clear so one pattern never matches twice
            st_nxt.rx_sh = 15'h0000;
            st_nxt.hist = {st_r.hist[8:0], rx_c};
            st_nxt.hval = {st_r.hval[8:0], 1'b1};
            for (int i = 0; i < 10; i++) begin
               if (4'(i) < win && st_nxt.hval[i] &&
                   st_nxt.hist[i] == rx_c) begin
                  cnt = cnt + 4'h1;
               end
            end
            if (cnt >= need && rx_c != st_r.rx_code) begin
               st_nxt.rx_code = rx_c;
            end
         end
      end
      // Set beats a same-cycle clear
      if (st_nxt.rx_code != st_r.rx_code) begin
         st_nxt.flag = 1'b1;
      end

      // Slot mapping, registered per slot position
      for (int k = 0; k < 2; k++) begin
         st_nxt.tx_ins[k] = st_r.tx_en[k+1] &
            slot_hit(st_r.tx_asg[k], st_r.tx_msk[k], tx_slot);
         st_nxt.rx_ext[k] = st_r.rx_en[k+1] &
            slot_hit(st_r.rx_asg[k], st_r.rx_msk[k], rx_slot);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
         st_r.tx_code <= `T1B_CODE_NONE;
         st_r.rx_code <= `T1B_CODE_NONE;
         st_r.tx_bit <= 1'b1;
         st_r.tx_st <= t1b_pkg::TX_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign awready = ~st_r.aw_ok & ~st_r.bvalid;
   assign wready = ~st_r.w_ok & ~st_r.bvalid;
   assign bvalid = st_r.bvalid;
   assign bresp = st_r.bresp;
   assign arready = ~st_r.rvalid;
   assign rvalid = st_r.rvalid;
   assign rdata = st_r.rdata;
   assign rresp = st_r.rresp;
   assign tx_dl_bit = st_r.tx_bit;
   assign tx_dl_active = st_r.tx_act;
   assign tx_ins = st_r.tx_ins;
   assign rx_ext = st_r.rx_ext;
   assign tx_link_en = {st_r.tx_en[2:1], st_r.tx_en[0] & lk1_ok};
   assign rx_link_en = {st_r.rx_en[2:1], st_r.rx_en[0] & lk1_ok};
   assign msg_irq = st_r.flag & st_r.irq_en;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   code_sets_flag_a: assert property (@(posedge aclk)
      disable iff (!aresetn) !$stable(st_r.rx_code) |-> st_r.flag)
      else $error("code update without flag");

   irq_masked_a: assert property (@(posedge aclk)
      disable iff (!aresetn) !st_r.irq_en |-> !msg_irq)
      else $error("interrupt while disabled");

   no_esf_tx_a: assert property (@(posedge aclk)
      disable iff (!aresetn) !esf |=> !tx_dl_active)
      else $error("message sent outside superframe");

   pat_head_a: assert property (@(posedge aclk)
      disable iff (!aresetn) $rose(tx_dl_active) |-> tx_dl_bit)
      else $error("pattern does not start with one");

   rx_hold_a: assert property (@(posedge aclk)
      disable iff (!aresetn) !esf |=> $stable(st_r.rx_code))
      else $error("code declared outside superframe");

   idle_code_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (esf && tx_dl_stb && st_r.tx_st == t1b_pkg::TX_IDLE &&
       st_r.tx_code == `T1B_CODE_NONE) |=> !tx_dl_active)
      else $error("all-ones code transmitted");

   no_select_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (st_r.tx_asg[0][6:5] == 2'b00) |=> !tx_ins[0])
      else $error("insert with both selects low");

   tx_dis_a: assert property (@(posedge aclk)
      disable iff (!aresetn) !st_r.tx_en[2] |=> !tx_ins[1])
      else $error("disabled link inserts");

   resp_hold_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (bvalid && !bready) |=> bvalid && $stable(bresp))
      else $error("write response dropped");

   link1_fmt_a: assert property (@(posedge aclk)
      disable iff (!aresetn) !lk1_ok |-> tx_link_en[0] == 1'b0)
      else $error("link 1 on in wrong format");

   flag_hold_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (st_r.flag && !(wr && st_r.widx == `T1B_IDX_MSGIND &&
                      st_r.wdat[0])) |=> st_r.flag)
      else $error("update flag lost without clear");

   rx_dis_a: assert property (@(posedge aclk)
      disable iff (!aresetn) !st_r.rx_en[1] |=> !rx_ext[0])
      else $error("disabled link extracts");

   mask_off_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (st_r.tx_msk[1] == 8'h00) |=> !tx_ins[1])
      else $error("insert with empty bit mask");

   rd_retire_a: assert property (@(posedge aclk)
      disable iff (!aresetn) (rvalid && rready) |=> !rvalid)
      else $error("read answer not retired");

endmodule : t1b_top

// ===== dv/t1b_line_model.sv
// Purpose: Far-end line model pacing data-link strobes both directions.
// Assumes: Device registers a data-link bit on the edge that sees a strobe.
// Notes:   Gap sets how slowly the far end paces its strobes.
`timescale 1ns/1ps

module t1b_line_model (
   input wire logic aclk,
   input wire logic tx_dl_bit,
   input wire logic tx_dl_active,
   output logic tx_dl_stb,
   output logic rx_dl_stb,
   output logic rx_dl_bit
);
   initial begin
      tx_dl_stb = 1'h0;
      rx_dl_stb = 1'h0;
      rx_dl_bit = 1'h0;
   end

   // Bit k goes out k-th: seven ones, a zero, code LSB first, a zero
   function automatic logic [14:0] msg_pat(input logic [5:0] c);
      return {1'h0, c, 8'h7F};
   endfunction : msg_pat

   task automatic send_msg(input logic [5:0] c, input int reps,
                           input int gap);
      logic [14:0] p;
      p = msg_pat(c);
      repeat (reps) begin
         for (int i = 0; i < 15; i++) begin
            @(posedge aclk);
            rx_dl_stb <= 1'h1;
            rx_dl_bit <= p[i];
            @(posedge aclk);
            rx_dl_stb <= 1'h0;
            // Stale data flips so the device cannot lean on it
            rx_dl_bit <= ~p[i];
            repeat (gap) @(posedge aclk);
         end
      end
   endtask : send_msg

   task automatic grab(input int first, input int n, input int gap,
                       inout logic [14:0] p, inout logic [14:0] a);
      for (int i = first; i < first + n; i++) begin
         @(posedge aclk);
         tx_dl_stb <= 1'h1;
         @(posedge aclk);
         tx_dl_stb <= 1'h0;
         @(posedge aclk);
         p[i] = tx_dl_bit;
         a[i] = tx_dl_active;
         repeat (gap) @(posedge aclk);
      end
   endtask : grab
endmodule : t1b_line_model

// ===== dv/t1b_tb_top.sv
// Purpose: Self-checking bench for message and slot mapping block.
// Assumes: Byte address is register index times four.
// Notes:   Each scenario task drives and judges on its own.
`timescale 1ns/1ps
`include "t1b_defines.svh"

module t1_bom_and_hdlc_slot_mapping_tb_top;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, msg_irq;
   logic tx_dl_stb, rx_dl_stb, rx_dl_bit, tx_dl_bit, tx_dl_active;
   logic [1:0] bresp, rresp, tx_ins, rx_ext;
   logic [2:0] tx_link_en, rx_link_en;
   t1b_pkg::t1b_slot_s tx_slot = '0, rx_slot = '0;
   int bad_count = 0, n_compared = 0;
   logic [14:0] p, a;

   t1b_top DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .tx_dl_stb,
      .rx_dl_stb, .rx_dl_bit, .tx_slot, .rx_slot, .tx_dl_bit,
      .tx_dl_active, .tx_ins, .rx_ext, .tx_link_en, .rx_link_en, .msg_irq);

   t1b_line_model LINE (.aclk, .tx_dl_bit, .tx_dl_active, .tx_dl_stb,
      .rx_dl_stb, .rx_dl_bit);

   initial begin
      forever #25 aclk = ~aclk;
   end

   // ----------------------------------------
   // Shared bus and compare tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask : chk

   task automatic wr(input logic [9:0] i, input logic [7:0] v,
                     input logic [1:0] er = `T1B_RESP_OKAY);
      int n;
      n = 0;
      awaddr <= {i, 2'h0};
      wdata <= {24'h0, v};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         n++;
      end while (bvalid !== 1'h1 && n < 50);
      chk("bresp", {1'h1, er}, {bvalid, bresp});
      bready <= 1'h0;
      @(posedge aclk);
   endtask : wr

   task automatic rd(input logic [9:0] i, input logic [31:0] e,
                     input logic [1:0] er = `T1B_RESP_OKAY);
      int n;
      n = 0;
      araddr <= {i, 2'h0};
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
         n++;
      end while (rvalid !== 1'h1 && n < 50);
      chk($sformatf("rdata %h", i), e, rdata);
      chk($sformatf("rresp %h", i), {1'h1, er}, {rvalid, rresp});
      rready <= 1'h0;
      @(posedge aclk);
   endtask : rd

   function automatic logic [5:0] rev6(input logic [5:0] c);
      for (int k = 0; k < 6; k++) rev6[k] = c[5 - k];
   endfunction : rev6

   task automatic slot(input logic o, input logic [4:0] c,
      input logic [2:0] b, input logic [1:0] et, input logic [1:0] er);
      tx_slot <= '{1'h1, o, c, b};
      rx_slot <= '{1'h1, o, c, b};
      @(posedge aclk);
      tx_slot.stb <= 1'h0;
      rx_slot.stb <= 1'h0;
      @(negedge aclk);
      chk("tx_ins", et, tx_ins);
      chk("rx_ext", er, rx_ext);
      @(posedge aclk);
   endtask : slot

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs;
      logic [9:0] ix [15] = '{`T1B_IDX_TXCODE, `T1B_IDX_MSGCTL,
         `T1B_IDX_MSGIND, `T1B_IDX_RXCODE, `T1B_IDX_TXEN, `T1B_IDX_TXASG2,
         `T1B_IDX_TXASG3, `T1B_IDX_TXMSK2, `T1B_IDX_TXMSK3, `T1B_IDX_RXEN,
         `T1B_IDX_RXASG2, `T1B_IDX_RXASG3, `T1B_IDX_RXMSK2,
         `T1B_IDX_RXMSK3, `T1B_IDX_FMT};
      foreach (ix[k]) rd(ix[k], (ix[k] == `T1B_IDX_TXCODE ||
         ix[k] == `T1B_IDX_RXCODE) ? 32'h3F : 32'h0);
      rd(10'h085, 32'h0, `T1B_RESP_SLVERR);
      wr(10'h085, 8'h55, `T1B_RESP_SLVERR);
      wr(`T1B_IDX_RXCODE, 8'h00);
      rd(`T1B_IDX_RXCODE, 32'h3F);
   endtask : t_regs

   task automatic t_link_en;
      wr(`T1B_IDX_TXEN, 8'h07);
      wr(`T1B_IDX_RXEN, 8'h07);
      chk("tx_link_en", 32'h6, tx_link_en);
      chk("rx_link_en", 32'h6, rx_link_en);
      for (int f = 1; f < 3; f++) begin
         wr(`T1B_IDX_FMT, f[7:0]);
         chk("tx_link_en", 32'h7, tx_link_en);
         chk("rx_link_en", 32'h7, rx_link_en);
      end
      wr(`T1B_IDX_TXEN, 8'h02);
      wr(`T1B_IDX_RXEN, 8'h04);
      chk("tx_link_en", 32'h2, tx_link_en);
      chk("rx_link_en", 32'h4, rx_link_en);
      wr(`T1B_IDX_TXEN, 8'h07);
      wr(`T1B_IDX_RXEN, 8'h07);
   endtask : t_link_en

   task automatic t_tx_msg;
      wr(`T1B_IDX_FMT, 8'h00);
      wr(`T1B_IDX_TXCODE, 8'h15);
      LINE.grab(0, 3, 1, p, a);
      chk("tx idle", 32'h7, {a[2:0], p[2:0]});
      wr(`T1B_IDX_FMT, 8'h01);
      wr(`T1B_IDX_TXCODE, 8'h3F);
      LINE.grab(0, 3, 0, p, a);
      chk("tx none", 32'h7, {a[2:0], p[2:0]});
      wr(`T1B_IDX_TXCODE, 8'h15);
      LINE.grab(0, 15, 0, p, a);
      chk("tx pattern", LINE.msg_pat(6'h15), p);
      chk("tx active", 32'h7FFF, a);
      LINE.grab(0, 7, 2, p, a);
      wr(`T1B_IDX_TXCODE, 8'h2A);
      LINE.grab(7, 8, 0, p, a);
      chk("tx old code", LINE.msg_pat(6'h15), p);
      LINE.grab(0, 15, 1, p, a);
      chk("tx new code", LINE.msg_pat(6'h2A), p);
      wr(`T1B_IDX_TXCODE, 8'h3F);
      LINE.grab(0, 15, 0, p, a);
      chk("tx stop", 32'h7FFF, {a[0], p});
      wr(`T1B_IDX_TXCODE, 8'h0A);
      LINE.grab(0, 5, 0, p, a);
      wr(`T1B_IDX_FMT, 8'h00);
      LINE.grab(0, 3, 0, p, a);
      chk("tx abort", 32'h7, {a[2:0], p[2:0]});
   endtask : t_tx_msg

   task automatic t_rx_msg;
      wr(`T1B_IDX_FMT, 8'h01);
      LINE.send_msg(6'h0B, 7, 0);
      rd(`T1B_IDX_MSGIND, 32'h0);
      LINE.send_msg(6'h0B, 1, 1);
      rd(`T1B_IDX_MSGIND, 32'h1);
      rd(`T1B_IDX_RXCODE, rev6(6'h0B));
      chk("msg_irq", 32'h0, msg_irq);
      wr(`T1B_IDX_MSGCTL, 8'h10);
      chk("msg_irq", 32'h1, msg_irq);
      wr(`T1B_IDX_MSGIND, 8'h00);
      rd(`T1B_IDX_MSGIND, 32'h1);
      wr(`T1B_IDX_MSGIND, 8'h01);
      rd(`T1B_IDX_MSGIND, 32'h0);
      chk("msg_irq", 32'h0, msg_irq);
      LINE.send_msg(6'h0B, 8, 0);
      rd(`T1B_IDX_MSGIND, 32'h0);
      wr(`T1B_IDX_MSGCTL, 8'h30);
      rd(`T1B_IDX_MSGCTL, 32'h30);
      LINE.send_msg(6'h2C, 3, 0);
      rd(`T1B_IDX_MSGIND, 32'h0);
      LINE.send_msg(6'h2C, 1, 2);
      rd(`T1B_IDX_MSGIND, 32'h1);
      rd(`T1B_IDX_RXCODE, rev6(6'h2C));
      chk("msg_irq", 32'h1, msg_irq);
      wr(`T1B_IDX_MSGIND, 8'h01);
      wr(`T1B_IDX_FMT, 8'h00);
      LINE.send_msg(6'h11, 8, 0);
      rd(`T1B_IDX_MSGIND, 32'h0);
      rd(`T1B_IDX_RXCODE, rev6(6'h2C));
   endtask : t_rx_msg

   task automatic t_slots;
      wr(`T1B_IDX_TXASG2, 8'h45);
      wr(`T1B_IDX_TXMSK2, 8'h80);
      wr(`T1B_IDX_TXASG3, 8'h37);
      wr(`T1B_IDX_TXMSK3, 8'h01);
      wr(`T1B_IDX_RXASG2, 8'h60);
      wr(`T1B_IDX_RXMSK2, 8'h18);
      wr(`T1B_IDX_RXASG3, 8'h05);
      wr(`T1B_IDX_RXMSK3, 8'hFF);
      rd(`T1B_IDX_TXASG3, 32'h37);
      slot(1'h0, 5'h05, 3'h0, 2'h1, 2'h0);
      slot(1'h1, 5'h05, 3'h0, 2'h0, 2'h0);
      slot(1'h0, 5'h05, 3'h1, 2'h0, 2'h0);
      slot(1'h0, 5'h06, 3'h0, 2'h0, 2'h0);
      slot(1'h1, 5'h17, 3'h7, 2'h2, 2'h0);
      slot(1'h0, 5'h17, 3'h7, 2'h0, 2'h0);
      slot(1'h1, 5'h00, 3'h3, 2'h0, 2'h1);
      slot(1'h0, 5'h00, 3'h4, 2'h0, 2'h1);
      slot(1'h0, 5'h00, 3'h2, 2'h0, 2'h0);
      wr(`T1B_IDX_TXEN, 8'h05);
      slot(1'h0, 5'h05, 3'h0, 2'h0, 2'h0);
      wr(`T1B_IDX_RXEN, 8'h05);
      slot(1'h1, 5'h00, 3'h3, 2'h0, 2'h0);
   endtask : t_slots

   task automatic conclude;
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude

   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      t_regs;
      t_link_en;
      t_tx_msg;
      t_rx_msg;
      t_slots;
      conclude;
   end

   // Run needs about 1400 cycles; this bound only catches a hang
   initial begin
      repeat (40000) @(posedge aclk);
      bad_count++;
      conclude;
   end
endmodule : t1_bom_and_hdlc_slot_mapping_tb_top
